// ### common/phy_rx_pkg.sv
package phy_rx_pkg;

    // ------------------------------------------------------------
    // MAC-side modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_MII    = 2'b00,
        MODE_RMII   = 2'b01,
        MODE_SERIAL = 2'b10
    } mac_mode_t;

    // ------------------------------------------------------------
    // Combined carrier/valid sequencing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CRS_IDLE   = 2'b00,
        CRS_ACTIVE = 2'b01,
        CRS_DRAIN  = 2'b10
    } crs_state_t;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int SQE_TIME_NS     = 1000;
    localparam int SQE_CYCLES_INT  = (SQE_TIME_NS / CLOCK_PERIOD_NS < 1) ? 1
                                   : SQE_TIME_NS / CLOCK_PERIOD_NS;
    localparam logic [5:0] SQE_CYCLES = 6'(SQE_CYCLES_INT);
    localparam logic [5:0] SQE_IDLE   = 6'h00;

    // ------------------------------------------------------------
    // Receive clock dividers, counted in reference edges (both edges)
    // ------------------------------------------------------------
    localparam logic [4:0] EDGES_MII100_PERIOD = 5'h02;
    localparam logic [4:0] EDGES_MII100_HIGH   = 5'h01;
    localparam logic [4:0] EDGES_MII10_PERIOD  = 5'h14;
    localparam logic [4:0] EDGES_MII10_HIGH    = 5'h0a;
    localparam logic [4:0] EDGES_SERIAL_PERIOD = 5'h05;
    localparam logic [4:0] EDGES_SERIAL_HIGH   = 5'h03;
    localparam logic [4:0] EDGE_COUNT_RESET    = 5'h00;

    // ------------------------------------------------------------
    // Data values
    // ------------------------------------------------------------
    localparam logic [3:0] RXD_RESET   = 4'h0;
    localparam logic [3:0] RXD_CORRUPT = 4'ha;
    localparam logic [1:0] DIBIT_MASK  = 2'h3;

endpackage

// ### rtl/rx_clock_gen.sv
`timescale 1ns/10ps

module rx_clock_gen
    import phy_rx_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Reference edges and shape
    input  wire logic       ref_edge,
    input  wire logic [4:0] period_edges,
    input  wire logic [4:0] high_edges,
    // Generated clock
    output logic            clk_level,
    output logic            rise_tick,
    output logic            fall_tick
);

    logic [4:0] count_q;
    logic [4:0] count_d;
    logic       level_q;
    logic       level_d;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        if (ref_edge) begin
            if (count_q + 5'h01 >= period_edges) begin
                count_d = EDGE_COUNT_RESET;
            end else begin
                count_d = count_q + 5'h01;
            end
        end
        level_d = (count_d < high_edges);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count_q <= EDGE_COUNT_RESET;
            level_q <= 1'b0;
        end else begin
            count_q <= count_d;
            level_q <= level_d;
        end
    end

    assign clk_level = level_q;
    assign rise_tick = level_d & ~level_q;
    assign fall_tick = ~level_d & level_q;

endmodule

// ### rtl/phy_mac_receive_interface.sv
`timescale 1ns/10ps

module phy_mac_receive_interface
    import phy_rx_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Configuration, static during operation
    input  wire logic [1:0] mode_select,
    input  wire logic       speed_100,
    input  wire logic       full_duplex,
    input  wire logic       heartbeat_enable,
    // Reference clock pin
    input  wire logic       ref_clock_input,
    // Receive path from the line side
    input  wire logic [3:0] line_data,
    input  wire logic       line_valid,
    input  wire logic       line_error,
    input  wire logic       medium_active,
    // Transmit activity from the transmit side
    input  wire logic       tx_active,
    // MAC-side receive pins
    output logic            rx_clock_out,
    output logic            rx_data_valid,
    output logic            rx_error,
    output logic [3:0]      rx_data,
    output logic            carrier_sense,
    output logic            collision,
    // Clock pins toward the system
    output logic            crystal_drive_output,
    output logic            ref_clock_forward_output
);

    // ------------------------------------------------------------
    // Reference clock sampling
    // ------------------------------------------------------------
    logic ref_meta_q;
    logic ref_sync_q;
    logic ref_prev_q;
    logic ref_any_edge;
    logic ref_fall;

    always_ff @(posedge clock) begin
        if (rst) begin
            ref_meta_q <= 1'b0;
            ref_sync_q <= 1'b0;
            ref_prev_q <= 1'b0;
        end else begin
            ref_meta_q <= ref_clock_input;
            ref_sync_q <= ref_meta_q;
            ref_prev_q <= ref_sync_q;
        end
    end

    assign ref_any_edge = ref_sync_q ^ ref_prev_q;
    assign ref_fall     = ~ref_sync_q & ref_prev_q;

    // ------------------------------------------------------------
    // Mode capture
    // ------------------------------------------------------------
    // The mode is taken once after reset so a glitch on the selection
    // cannot switch protocols in the middle of a frame.
    mac_mode_t mode_q;
    mac_mode_t mode_d;
    logic      mode_taken_q;
    logic      mode_taken_d;

    always_comb begin
        mode_d       = mode_q;
        mode_taken_d = 1'b1;
        if (!mode_taken_q) begin
            case (mode_select)
                MODE_RMII:   mode_d = MODE_RMII;
                MODE_SERIAL: mode_d = MODE_SERIAL;
                default:     mode_d = MODE_MII;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q       <= MODE_MII;
            mode_taken_q <= 1'b0;
        end else begin
            mode_q       <= mode_d;
            mode_taken_q <= mode_taken_d;
        end
    end

    // ------------------------------------------------------------
    // Receive clock generation
    // ------------------------------------------------------------
    logic [4:0] period_edges;
    logic [4:0] high_edges;
    logic       gen_level;
    logic       gen_fall;

    assign period_edges = (mode_q == MODE_SERIAL) ? EDGES_SERIAL_PERIOD :
                          speed_100 ? EDGES_MII100_PERIOD : EDGES_MII10_PERIOD;
    assign high_edges   = (mode_q == MODE_SERIAL) ? EDGES_SERIAL_HIGH :
                          speed_100 ? EDGES_MII100_HIGH : EDGES_MII10_HIGH;

    rx_clock_gen i_rx_clock_gen (
        .clock        (clock),
        .rst          (rst),
        .ref_edge     (ref_any_edge),
        .period_edges (period_edges),
        .high_edges   (high_edges),
        .clk_level    (gen_level),
        .rise_tick    (),
        .fall_tick    (gen_fall)
    );

    // Data, valid, error and carrier change on the falling edge of their timing clock so the MAC
    // samples them on the rising edge with the low time as setup: half a period, two fifths in serial mode.
    logic data_tick;
    logic is_rmii;

    assign is_rmii   = (mode_q == MODE_RMII);
    assign data_tick = is_rmii ? ref_fall : gen_fall;

    // ------------------------------------------------------------
    // Combined carrier/valid sequencer
    // ------------------------------------------------------------
    crs_state_t crs_state_q;
    crs_state_t crs_state_d;
    logic       crs_toggle_q;
    logic       crs_toggle_d;

    always_comb begin
        crs_state_d  = crs_state_q;
        crs_toggle_d = crs_toggle_q;
        if (data_tick) begin
            case (crs_state_q)
                CRS_IDLE: begin
                    crs_toggle_d = 1'b0;
                    if (medium_active) begin
                        crs_state_d = CRS_ACTIVE;
                    end
                end
                CRS_ACTIVE: begin
                    crs_toggle_d = 1'b0;
                    if (!medium_active) begin
                        crs_state_d = line_valid ? CRS_DRAIN : CRS_IDLE;
                    end
                end
                CRS_DRAIN: begin
                    // Carrier gone but data pending: alternate per dibit.
                    crs_toggle_d = ~crs_toggle_q;
                    if (!line_valid) begin
                        crs_state_d  = CRS_IDLE;
                        crs_toggle_d = 1'b0;
                    end
                end
                default: begin
                    crs_state_d  = CRS_IDLE;
                    crs_toggle_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            crs_state_q  <= CRS_IDLE;
            crs_toggle_q <= 1'b0;
        end else begin
            crs_state_q  <= crs_state_d;
            crs_toggle_q <= crs_toggle_d;
        end
    end

    // ------------------------------------------------------------
    // Receive data path
    // ------------------------------------------------------------
    logic [3:0] rxd_q;
    logic [3:0] rxd_d;
    logic       dv_q;
    logic       dv_d;
    logic       er_q;
    logic       er_d;
    logic       crs_q;
    logic       crs_d;
    logic       bad_symbol;

    assign bad_symbol = line_error & line_valid;

    always_comb begin
        rxd_d = rxd_q;
        dv_d  = dv_q;
        er_d  = er_q;
        crs_d = crs_q;
        if (data_tick) begin
            case (mode_q)
                MODE_RMII: begin
                    dv_d  = line_valid;
                    er_d  = speed_100 & bad_symbol;
                    rxd_d = {2'b00, line_data[1:0]};
                    if (bad_symbol) begin
                        rxd_d = {2'b00, RXD_CORRUPT[1:0] & DIBIT_MASK};
                    end
                    crs_d = (crs_state_d == CRS_ACTIVE) |
                            ((crs_state_d == CRS_DRAIN) & ~crs_toggle_d);
                end
                MODE_SERIAL: begin
                    dv_d  = 1'b0;
                    er_d  = 1'b0;
                    crs_d = medium_active;
                    rxd_d = {3'b000, line_data[0] & medium_active};
                end
                default: begin
                    dv_d  = line_valid;
                    er_d  = speed_100 & bad_symbol;
                    rxd_d = line_valid ? line_data : RXD_RESET;
                    if (bad_symbol) begin
                        rxd_d = RXD_CORRUPT;
                    end
                    crs_d = medium_active;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rxd_q <= RXD_RESET;
            dv_q  <= 1'b0;
            er_q  <= 1'b0;
            crs_q <= 1'b0;
        end else begin
            rxd_q <= rxd_d;
            dv_q  <= dv_d;
            er_q  <= er_d;
            crs_q <= crs_d;
        end
    end

    // ------------------------------------------------------------
    // Collision and heartbeat
    // ------------------------------------------------------------
    logic       tx_prev_q;
    logic       col_q;
    logic       col_d;
    logic [5:0] sqe_q;
    logic [5:0] sqe_d;
    logic       sqe_allowed;

    assign sqe_allowed = (mode_q != MODE_RMII) & ~speed_100 & ~full_duplex & heartbeat_enable;

    always_comb begin
        sqe_d = sqe_q;
        if (!sqe_allowed) begin
            sqe_d = SQE_IDLE;
        end else if (tx_prev_q & ~tx_active) begin
            sqe_d = SQE_CYCLES;
        end else if (sqe_q != SQE_IDLE) begin
            sqe_d = sqe_q - 6'h01;
        end
        col_d = 1'b0;
        if (!is_rmii && !full_duplex) begin
            // Same rule in both modes; serial is always half speed.
            col_d = (tx_active & medium_active) | (sqe_q != SQE_IDLE);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_prev_q <= 1'b0;
            sqe_q     <= SQE_IDLE;
            col_q     <= 1'b0;
        end else begin
            tx_prev_q <= tx_active;
            sqe_q     <= sqe_d;
            col_q     <= col_d;
        end
    end

    // ------------------------------------------------------------
    // Clock outputs and pins
    // ------------------------------------------------------------
    logic rxclk_q;
    logic rxclk_d;
    logic fwd_q;
    logic xdrv_q;

    always_comb begin
        rxclk_d = is_rmii ? 1'b0 : gen_level;
    end

    // The forwarded clock carries the resampled reference, so its edges
    // land on the internal clock grid; jitter is one internal period.
    always_ff @(posedge clock) begin
        if (rst) begin
            rxclk_q <= 1'b0;
            fwd_q   <= 1'b0;
            xdrv_q  <= 1'b1;
        end else begin
            rxclk_q <= rxclk_d;
            fwd_q   <= ref_sync_q;
            xdrv_q  <= ~ref_sync_q;
        end
    end

    assign rx_clock_out             = rxclk_q;
    assign rx_data_valid            = dv_q;
    assign rx_error                 = er_q;
    assign rx_data                  = rxd_q;
    assign carrier_sense            = crs_q;
    assign collision                = col_q;
    assign crystal_drive_output     = xdrv_q;
    assign ref_clock_forward_output = fwd_q;

endmodule

// ### verif/phy_rx_checker.sv
`timescale 1ns/10ps

module phy_rx_checker
    import phy_rx_pkg::*;
(
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // Configuration and causes
    input wire logic [1:0] mode_select,
    input wire logic       speed_100,
    input wire logic       full_duplex,
    input wire logic       heartbeat_enable,
    input wire logic       medium_active,
    input wire logic       tx_active,
    // Observed outputs
    input wire logic       rx_clock_out,
    input wire logic       rx_data_valid,
    input wire logic       rx_error,
    input wire logic [3:0] rx_data,
    input wire logic       collision,
    input wire logic       crystal_drive_output,
    input wire logic       ref_clock_forward_output
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // The bench changes the mode only under reset, so the pins stand for the latched mode.
    a_rmii_clk_low: assert property (mode_select == MODE_RMII |-> !rx_clock_out)
        else $error("receive clock active in reduced mode");
    a_serial_no_dv: assert property (mode_select == MODE_SERIAL |-> !rx_data_valid)
        else $error("data valid driven in serial mode");
    a_serial_upper: assert property (mode_select == MODE_SERIAL |-> rx_data[3:1] == 3'h0)
        else $error("upper data bits driven in serial mode");
    a_rmii_upper: assert property (mode_select == MODE_RMII |-> rx_data[3:2] == 2'h0)
        else $error("upper data bits driven in reduced mode");
    a_fdx_no_col: assert property (full_duplex && $past(full_duplex) |-> !collision)
        else $error("collision in full duplex");
    a_rmii_no_col: assert property (mode_select == MODE_RMII |-> !collision)
        else $error("collision driven in reduced mode");
    a_overlap_col: assert property (mode_select != MODE_RMII && !full_duplex
        && tx_active && medium_active |=> collision) else $error("overlap gave no collision");
    a_err_100_only: assert property (!speed_100 || mode_select == MODE_SERIAL |-> !rx_error)
        else $error("receive error outside 100 Mb/s");
    a_sqe_pulse: assert property ($fell(tx_active) && !speed_100 && !full_duplex
        && heartbeat_enable && mode_select != MODE_RMII |-> ##3 collision [*8])
        else $error("heartbeat pulse missing");
    a_mii_on_fall: assert property (mode_select == MODE_MII
        && ($changed(rx_data) || $changed(rx_data_valid)) |=> $fell(rx_clock_out))
        else $error("receive data changed off the clock fall");
    a_fwd_inverse: assert property (crystal_drive_output != ref_clock_forward_output)
        else $error("crystal drive not inverse of forwarded clock");

    c_col: cover property ($rose(collision));
    c_err: cover property ($rose(rx_error));
    c_dv: cover property ($rose(rx_data_valid));
endmodule

bind phy_mac_receive_interface phy_rx_checker i_phy_rx_checker (
    .clock(clock), .rst(rst), .mode_select(mode_select), .speed_100(speed_100),
    .full_duplex(full_duplex), .heartbeat_enable(heartbeat_enable),
    .medium_active(medium_active), .tx_active(tx_active), .rx_clock_out(rx_clock_out),
    .rx_data_valid(rx_data_valid), .rx_error(rx_error), .rx_data(rx_data),
    .collision(collision), .crystal_drive_output(crystal_drive_output),
    .ref_clock_forward_output(ref_clock_forward_output)
);

// ### verif/mac_rx_model.sv
`timescale 1ns/10ps

module mac_rx_model
    import phy_rx_pkg::*;
(
    // Clock
    input  wire logic       clock,
    // Receive pins
    input  wire logic       rx_clock_out,
    input  wire logic [3:0] rx_data,
    input  wire logic       carrier_sense,
    // Own transmit enable
    input  wire logic       mac_tx_en,
    // Observations
    output logic [3:0]      got_data,
    output logic [7:0]      rise_gap,
    output logic            rmii_col
);
    logic       prev_clk;
    logic [7:0] gap;

    initial begin
        prev_clk = 1'b0;
        gap = 8'h00;
        got_data = 4'h0;
        rise_gap = 8'h00;
    end

    always @(posedge clock) begin
        prev_clk <= rx_clock_out;
        gap <= gap + 8'h01;
        if (rx_clock_out && !prev_clk) begin
            got_data <= rx_data;
            rise_gap <= gap + 8'h01;
            gap <= 8'h00;
        end
    end

    // No collision pin in reduced mode, so the MAC builds its own.
    assign rmii_col = carrier_sense & mac_tx_en;
endmodule

// ### verif/test_phy_mac_receive_interface.sv
`timescale 1ns/10ps

module test_phy_mac_receive_interface;
    import phy_rx_pkg::*;

    logic       clock, rst, speed_100, full_duplex, heartbeat_enable, ref_clock_input;
    logic [1:0] mode_select;
    logic [3:0] line_data, rx_data, got_data;
    logic       line_valid, line_error, medium_active, tx_active, rmii_col;
    logic       rx_clock_out, rx_data_valid, rx_error, carrier_sense, collision;
    logic       crystal_drive_output, ref_clock_forward_output, fwd_prev;
    logic [7:0] rise_gap, cnt, toggles;
    int         n_errors, tests_run;

    phy_mac_receive_interface i_phy_mac_receive_interface (.clock(clock), .rst(rst),
        .mode_select(mode_select), .speed_100(speed_100), .full_duplex(full_duplex),
        .heartbeat_enable(heartbeat_enable), .ref_clock_input(ref_clock_input),
        .line_data(line_data), .line_valid(line_valid), .line_error(line_error),
        .medium_active(medium_active), .tx_active(tx_active), .rx_clock_out(rx_clock_out),
        .rx_data_valid(rx_data_valid), .rx_error(rx_error), .rx_data(rx_data),
        .carrier_sense(carrier_sense), .collision(collision),
        .crystal_drive_output(crystal_drive_output),
        .ref_clock_forward_output(ref_clock_forward_output));

    mac_rx_model i_mac_rx_model (.clock(clock), .rx_clock_out(rx_clock_out),
        .rx_data(rx_data), .carrier_sense(carrier_sense), .mac_tx_en(tx_active),
        .got_data(got_data), .rise_gap(rise_gap), .rmii_col(rmii_col));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // The reference runs free with an odd phase against the system clock.
    initial begin
        ref_clock_input = 1'b0;
        #13;
        forever #200 ref_clock_input = ~ref_clock_input;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic send(input logic [3:0] d, input logic v, input logic e, input logic m);
        line_data = d;
        line_valid = v;
        line_error = e;
        medium_active = m;
    endtask

    task automatic start(input logic [1:0] m, input logic s, input logic f, input logic h);
        @(negedge clock);
        rst = 1'b1;
        mode_select = m;
        speed_100 = s;
        full_duplex = f;
        heartbeat_enable = h;
        tx_active = 1'b0;
        send(4'h0, 1'b0, 1'b0, 1'b0);
        wait_n(10);
        check("reset crystal", 8'(crystal_drive_output), 8'h01);
        check("reset data", {rx_clock_out, rx_data_valid, carrier_sense, rx_data}, 8'h00);
        rst = 1'b0;
        wait_n(2);
    endtask

    task automatic count_col(input int n);
        cnt = 8'h00;
        repeat (n) begin
            @(negedge clock);
            cnt += 8'(collision);
        end
    endtask

    task automatic t_mii100();
        start(MODE_MII, 1'b1, 1'b0, 1'b0);
        send(4'h5, 1'b1, 1'b0, 1'b1);
        wait_n(20);
        check("mii data", 8'(rx_data), 8'h05);
        check("mii dv", 8'(rx_data_valid), 8'h01);
        check("mii crs", 8'(carrier_sense), 8'h01);
        check("mac data", 8'(got_data), 8'h05);
        check("mii100 period", rise_gap, 8'h08);
        send(4'h3, 1'b1, 1'b1, 1'b1);
        wait_n(20);
        check("mii err", 8'(rx_error), 8'h01);
        check("mii corrupt", 8'(rx_data), 8'h0a);
        send(4'h0, 1'b0, 1'b0, 1'b0);
        wait_n(20);
        check("mii idle", {carrier_sense, rx_data_valid}, 8'h00);
        cnt = 8'h00;
        toggles = 8'h00;
        fwd_prev = ref_clock_forward_output;
        repeat (80) begin
            @(negedge clock);
            toggles += 8'(ref_clock_forward_output != fwd_prev);
            fwd_prev = ref_clock_forward_output;
            cnt += 8'(ref_clock_forward_output ^ crystal_drive_output ? 1'b0 : 1'b1);
        end
        check("fwd clock", cnt, 8'h00);
        check("fwd toggles", toggles, 8'h14);
    endtask

    task automatic t_mii10();
        start(MODE_MII, 1'b0, 1'b0, 1'b1);
        send(4'h9, 1'b1, 1'b1, 1'b1);
        wait_n(200);
        check("mii10 no err", 8'(rx_error), 8'h00);
        check("mii10 period", rise_gap, 8'h50);
        tx_active = 1'b1;
        wait_n(3);
        check("mii overlap", 8'(collision), 8'h01);
        send(4'h0, 1'b0, 1'b0, 1'b0);
        wait_n(3);
        check("mii no overlap", 8'(collision), 8'h00);
        tx_active = 1'b0;
        count_col(40);
        check("heartbeat", cnt, 8'd20);
    endtask

    task automatic t_full();
        start(MODE_MII, 1'b0, 1'b1, 1'b1);
        send(4'h0, 1'b0, 1'b0, 1'b1);
        tx_active = 1'b1;
        wait_n(5);
        tx_active = 1'b0;
        count_col(40);
        check("fdx col", cnt, 8'h00);
    endtask

    task automatic t_rmii();
        start(MODE_RMII, 1'b1, 1'b0, 1'b0);
        send(4'hd, 1'b1, 1'b0, 1'b1);
        tx_active = 1'b1;
        wait_n(20);
        check("rmii dibit", 8'(rx_data), 8'h01);
        check("rmii clk", 8'(rx_clock_out), 8'h00);
        check("rmii crs_dv", 8'(carrier_sense), 8'h01);
        check("mac col", {collision, rmii_col}, 8'h01);
        tx_active = 1'b0;
        send(4'hf, 1'b1, 1'b1, 1'b1);
        wait_n(20);
        check("rmii err", 8'(rx_error), 8'h01);
        check("rmii corrupt", 8'(rx_data), 8'h02);
        send(4'h1, 1'b1, 1'b0, 1'b0);
        cnt = 8'h00;
        repeat (40) begin
            @(negedge clock);
            cnt += 8'(carrier_sense);
        end
        check("crs_dv toggles", 8'(cnt > 8'd5 && cnt < 8'd35), 8'h01);
        check("rmii dv", 8'(rx_data_valid), 8'h01);
        send(4'h0, 1'b0, 1'b0, 1'b0);
        wait_n(20);
        check("rmii idle", {carrier_sense, rx_data_valid}, 8'h00);
    endtask

    task automatic t_serial();
        start(MODE_SERIAL, 1'b0, 1'b0, 1'b0);
        send(4'hf, 1'b1, 1'b1, 1'b1);
        wait_n(50);
        check("ser data", 8'(rx_data), 8'h01);
        check("ser crs", {carrier_sense, rx_data_valid, rx_error}, 8'h04);
        check("ser period", rise_gap, 8'h14);
        tx_active = 1'b1;
        wait_n(3);
        check("ser col", 8'(collision), 8'h01);
        tx_active = 1'b0;
        send(4'hf, 1'b1, 1'b0, 1'b0);
        wait_n(50);
        check("ser idle", {carrier_sense, rx_data}, 8'h00);
    endtask

    initial begin
        n_errors = 0;
        tests_run = 0;
        rst = 1'b1;
        mode_select = MODE_MII;
        {speed_100, full_duplex, heartbeat_enable, tx_active} = 4'h0;
        send(4'h0, 1'b0, 1'b0, 1'b0);
        t_mii100();
        t_mii10();
        t_full();
        t_rmii();
        t_serial();
        end_sim();
    end

    initial begin
        #1000000;
        n_errors++;
        end_sim();
    end
endmodule
